/* File: rtl/dcb_pkg.sv */
package dcb_pkg;
   // Geometry of the command interface.
   localparam int BANKS = 8;
   localparam int BA_W = 3;
   localparam int ADDR_W = 13;
   localparam int ROW_W = 13;
   localparam int COL_W = 10;
   localparam int AP_BIT = 10;
   // Highest additive latency the device accepts.
   localparam int AL_MAX = 6;
   // Burst length choices and write recovery default.
   localparam logic [3:0] BL_FOUR = 4'h4;
   localparam logic [3:0] BL_EIGHT = 4'h8;
   localparam logic [2:0] WR_RESET = 3'h2;
   localparam logic [2:0] AL_RESET = 3'h0;
   // Self refresh internal refresh period, in ns, and its cycle count.
   localparam int SREF_PERIOD_NS = 7800;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SREF_CYC = SREF_PERIOD_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam int DLY_W = 5;
   // Decoded command kinds.
   typedef enum logic [7:0] {
      DCB_CMD_NOP = 8'h01,
      DCB_CMD_ACT = 8'h02,
      DCB_CMD_RD = 8'h04,
      DCB_CMD_WR = 8'h08,
      DCB_CMD_PRE = 8'h10,
      DCB_CMD_REF = 8'h20,
      DCB_CMD_SRE = 8'h40,
      DCB_CMD_OTH = 8'h80
   } dcb_cmd_e;
   // Device power state.
   typedef enum logic [1:0] {
      DCB_ST_RUN = 2'h1,
      DCB_ST_SREF = 2'h2
   } dcb_st_e;
endpackage : dcb_pkg

/* File: rtl/dcb_core.sv */
`timescale 1ns/1ps
// How it works
// - Activate is CS, RAS low, CAS, WE high; bank bits and row open.
// - Banks are activated before access; access may follow activate next clock.
// - Additive latency 0 to 6 delays internal read or write issue.
// - Read is CS, CAS low, RAS, WE high; column on address 0 to 9.
// - Write is CS, CAS, WE low, RAS high; bursts into open row.
// - Address 10 high on access closes the row at burst end, after write recovery for writes.
// - Read auto-precharge starts AL plus BL/2 clocks after the command.
// - Write auto-precharge starts after burst end plus write recovery.
// - Precharge-all with address 10 high closes every bank, ignoring bank bits.
// - In self refresh, internal timer refreshes, DLL off, only CKE watched.
// - Refresh is CS, RAS, CAS low, WE, CKE high; banks idle afterwards.
// - CS low with RAS, CAS, WE high is a no-operation.
// - CS high disables the decoder; strobes and address are ignored.
module dcb_core #(
   parameter int SREF_CYCLES = dcb_pkg::SREF_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic [dcb_pkg::BA_W-1:0] bank,
   input wire logic [dcb_pkg::ADDR_W-1:0] addr,
   input wire logic [2:0] add_lat,
   input wire logic burst_eight,
   input wire logic [2:0] wr_recovery,
   output logic [dcb_pkg::BANKS-1:0] bank_open,
   output logic [dcb_pkg::ROW_W-1:0] open_row [dcb_pkg::BANKS],
   output logic rd_issue,
   output logic wr_issue,
   output logic [dcb_pkg::BA_W-1:0] issue_bank,
   output logic [dcb_pkg::COL_W-1:0] issue_col,
   output logic ap_pulse,
   output logic [dcb_pkg::BA_W-1:0] ap_bank,
   output logic self_refresh,
   output logic dll_enable,
   output logic int_refresh,
   output logic [dcb_pkg::CNT_W-1:0] refresh_count
);
   import dcb_pkg::*;

   // One pending delayed access slot per bank.
   typedef struct packed {
      logic pend;
      logic early; // Zero additive latency, so the issue edge comes one clock late.
      logic wr;
      logic ap;
      logic [COL_W-1:0] col;
      logic [DLY_W-1:0] dly;
   } dcb_slot_s;

   typedef struct packed {
      dcb_st_e st;
      logic [BANKS-1:0] open;
      logic [BANKS-1:0][ROW_W-1:0] row;
      dcb_slot_s [BANKS-1:0] slot;
      logic [BANKS-1:0] apq;
      logic [BANKS-1:0][DLY_W-1:0] apd;
      logic rd;
      logic wr;
      logic [BA_W-1:0] ib;
      logic [COL_W-1:0] ic;
      logic ap;
      logic [BA_W-1:0] apb;
      logic [CNT_W-1:0] stmr;
      logic iref;
      logic [CNT_W-1:0] rcnt;
      logic cks1;
      logic cks2;
   } dcb_state_s;

   dcb_state_s state_reg;
   dcb_state_s state_next;
   dcb_cmd_e cmd;
   logic [3:0] half_bl;

   // Turns the strobe pins into a command kind.
   function automatic dcb_cmd_e dcb_decode(input logic c, input logic r, input logic a,
                                           input logic w, input logic k);
      dcb_cmd_e res;
      res = DCB_CMD_OTH;
      if (c) begin
         res = DCB_CMD_NOP;
      end else begin
         unique case ({r, a, w})
            3'b111: res = DCB_CMD_NOP;
            3'b011: res = DCB_CMD_ACT;
            3'b101: res = DCB_CMD_RD;
            3'b100: res = DCB_CMD_WR;
            3'b010: res = DCB_CMD_PRE;
            3'b001: res = k ? DCB_CMD_REF : DCB_CMD_SRE;
            default: res = DCB_CMD_OTH;
         endcase
      end
      return res;
   endfunction : dcb_decode

   // The decoder sees CKE only after its second synchroniser flop.
   assign cmd = dcb_decode(cs_n, ras_n, cas_n, we_n, state_reg.cks2);
   assign half_bl = burst_eight ? (BL_EIGHT >> 1) : (BL_FOUR >> 1);

   // Next-state logic for bank tracking, posted accesses and self refresh.
   always_comb begin
      state_next = state_reg;
      state_next.rd = 1'b0;
      state_next.wr = 1'b0;
      state_next.ap = 1'b0;
      state_next.iref = 1'b0;
      // The CKE pin passes two flops before any logic reads it.
      state_next.cks1 = cke;
      state_next.cks2 = state_reg.cks1;
      if (state_reg.st == DCB_ST_SREF) begin
         // Internal timer keeps the array alive; pins other than CKE ignored.
         if (state_reg.stmr == CNT_W'(SREF_CYCLES - 1)) begin
            state_next.stmr = '0;
            state_next.iref = 1'b1;
            state_next.rcnt = state_reg.rcnt + CNT_W'(1);
         end else begin
            state_next.stmr = state_reg.stmr + CNT_W'(1);
         end
         if (state_reg.cks2) begin
            state_next.st = DCB_ST_RUN;
         end
      end else begin
         // Posted accesses and pending auto-precharges count down per bank.
         for (int b = 0; b < BANKS; b++) begin
            if (state_reg.slot[b].pend) begin
               if (state_reg.slot[b].dly == '0) begin
                  state_next.slot[b].pend = 1'b0;
                  state_next.rd = ~state_reg.slot[b].wr;
                  state_next.wr = state_reg.slot[b].wr;
                  state_next.ib = BA_W'(b);
                  state_next.ic = state_reg.slot[b].col;
                  if (state_reg.slot[b].ap) begin
                     state_next.apq[b] = 1'b1;
                     state_next.apd[b] = state_reg.slot[b].wr
                        ? DLY_W'(half_bl) + DLY_W'(wr_recovery) - DLY_W'(1)
                        : DLY_W'(half_bl) - DLY_W'(1)
                          - DLY_W'(state_reg.slot[b].early);
                  end
               end else begin
                  state_next.slot[b].dly = state_reg.slot[b].dly - DLY_W'(1);
               end
            end
            if (state_reg.apq[b]) begin
               if (state_reg.apd[b] == '0) begin
                  state_next.apq[b] = 1'b0;
                  state_next.open[b] = 1'b0;
                  state_next.ap = 1'b1;
                  state_next.apb = BA_W'(b);
               end else begin
                  state_next.apd[b] = state_reg.apd[b] - DLY_W'(1);
               end
            end
         end
         unique case (cmd)
            DCB_CMD_ACT: begin
               state_next.open[bank] = 1'b1;
               state_next.row[bank] = addr[ROW_W-1:0];
            end
            DCB_CMD_RD, DCB_CMD_WR: begin
               if (state_reg.open[bank]) begin
                  state_next.slot[bank].pend = 1'b1;
                  state_next.slot[bank].wr = (cmd == DCB_CMD_WR);
                  state_next.slot[bank].ap = addr[AP_BIT];
                  state_next.slot[bank].col = addr[COL_W-1:0];
                  state_next.slot[bank].early = (add_lat == '0);
                  state_next.slot[bank].dly = (add_lat > 3'(AL_MAX))
                     ? DLY_W'(AL_MAX) - DLY_W'(1) : DLY_W'(add_lat) - DLY_W'(1);
                  if (add_lat == '0) begin
                     // Zero latency issues on the very next edge.
                     state_next.slot[bank].dly = '0;
                  end
               end
            end
            DCB_CMD_PRE: begin
               if (addr[AP_BIT]) begin
                  state_next.open = '0;
                  state_next.apq = '0;
               end else begin
                  state_next.open[bank] = 1'b0;
                  state_next.apq[bank] = 1'b0;
               end
            end
            DCB_CMD_REF: begin
               state_next.open = '0;
               state_next.iref = 1'b1;
               state_next.rcnt = state_reg.rcnt + CNT_W'(1);
            end
            DCB_CMD_SRE: begin
               state_next.st = DCB_ST_SREF;
               state_next.stmr = '0;
               state_next.open = '0;
            end
            DCB_CMD_NOP, DCB_CMD_OTH: begin
               state_next.st = state_reg.st;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '{st: DCB_ST_RUN, default: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs come straight from the state register.
   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         open_row[b] = state_reg.row[b];
      end
   end
   assign bank_open = state_reg.open;
   assign rd_issue = state_reg.rd;
   assign wr_issue = state_reg.wr;
   assign issue_bank = state_reg.ib;
   assign issue_col = state_reg.ic;
   assign ap_pulse = state_reg.ap;
   assign ap_bank = state_reg.apb;
   assign self_refresh = (state_reg.st == DCB_ST_SREF);
   assign dll_enable = (state_reg.st != DCB_ST_SREF);
   assign int_refresh = state_reg.iref;
   assign refresh_count = state_reg.rcnt;
endmodule : dcb_core

/* File: tb/dcb_ctrl_model.sv */
`timescale 1ns/1ps
// Controller side: one command at a time, then the spacing the device needs.
module dcb_ctrl_model (
   input wire logic sys_clk,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] bank,
   output logic [12:0] addr,
   output logic odt
);
   initial {cs_n, ras_n, cas_n, we_n, bank, addr} = '1;
   // Termination stays off: the model never updates its strength, so no glitch can arise.
   initial odt = 1'b0;
   // Deselect cycles toggle the ignored pins so a stale value never looks valid.
   task automatic nop(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         cs_n <= 1'b1;
         {ras_n, cas_n, we_n, bank, addr} <= ~{ras_n, cas_n, we_n, bank, addr};
      end
   endtask : nop
   // The gap covers row to column delay, activate spacing, precharge and refresh times.
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a, int gap);
      @(posedge sys_clk);
      {cs_n, ras_n, cas_n, we_n} <= c;
      bank <= b;
      addr <= a;
      nop(gap);
   endtask : cmd
endmodule : dcb_ctrl_model

/* File: tb/dcb_core_monitor.sv */
`timescale 1ns/1ps
// Checks decode, posted issue timing and self refresh at the core's pins.
module dcb_core_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic burst_eight,
   input wire logic [2:0] bank,
   input wire logic [2:0] add_lat,
   input wire logic [2:0] wr_recovery,
   input wire logic [2:0] issue_bank,
   input wire logic [2:0] ap_bank,
   input wire logic [12:0] addr,
   input wire logic [7:0] bank_open,
   input wire logic rd_issue,
   input wire logic wr_issue,
   input wire logic ap_pulse,
   input wire logic self_refresh,
   input wire logic dll_enable,
   input wire logic int_refresh
);
   wire logic [3:0] c = {cs_n, ras_n, cas_n, we_n};
   wire logic ok = bank_open[bank] && !self_refresh;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Auto-precharge accesses as the bench sets them up.
   sequence s_rd_ap;
      c == 4'h5 && addr[10] && ok && add_lat == 3'h2 && !burst_eight;
   endsequence
   sequence s_rd_ap0;
      c == 4'h5 && addr[10] && ok && add_lat == 3'h0 && !burst_eight;
   endsequence
   sequence s_wr_ap;
      c == 4'h4 && addr[10] && ok && add_lat == 3'h1 && burst_eight && wr_recovery == 3'h3;
   endsequence
   a_act_open:
      assert property (c == 4'h3 && !self_refresh |=> bank_open[$past(bank)]) else $error("no open");
   a_rd_latency:
      assert property (c == 4'h5 && !addr[10] && ok && add_lat == 3'h1
         |=> ##1 rd_issue && issue_bank == $past(bank, 2)) else $error("read issue late");
   a_rd_ap_close:
      assert property (s_rd_ap |-> ##3 rd_issue ##2 ap_pulse && ap_bank == $past(bank, 5)
         && !bank_open[ap_bank]) else $error("read precharge");
   a_rd_ap_zero:
      assert property (s_rd_ap0 |-> ##2 rd_issue ##1 ap_pulse && ap_bank == $past(bank, 3))
         else $error("read precharge at zero latency");
   a_wr_ap_close:
      assert property (s_wr_ap |-> ##2 wr_issue ##7 ap_pulse && ap_bank == $past(bank, 9))
         else $error("write precharge");
   a_pre_all:
      assert property (c == 4'h2 && addr[10] && !self_refresh |=> bank_open == 8'h00)
         else $error("banks left open");
   a_ref_close:
      assert property (c == 4'h1 && cke && $past(cke) && $past(cke, 2) && !$past(rst)
         && !$past(rst, 2) && !self_refresh |=> int_refresh && bank_open == 8'h00)
         else $error("refresh");
   a_idle_keep:
      assert property (cs_n || c == 4'h7 |=> (bank_open & ~$past(bank_open)) == 8'h00)
         else $error("idle opened bank");
   a_sref_deaf:
      assert property (self_refresh |-> !dll_enable ##1 (bank_open & ~$past(bank_open)) == 8'h00)
         else $error("self refresh");
   a_sre_enter:
      assert property ((!cke)[*2] ##1 (c == 4'h1 && !cke && !self_refresh) |=> self_refresh)
         else $error("no entry");
   a_sref_exit:
      assert property (self_refresh && $rose(cke) ##1 cke[*2] |=> !self_refresh && dll_enable)
         else $error("no exit");
endmodule : dcb_core_monitor
bind dcb_core dcb_core_monitor mon (.sys_clk, .rst, .cs_n, .ras_n, .cas_n, .we_n, .cke,
   .burst_eight, .bank, .add_lat, .wr_recovery, .issue_bank, .ap_bank, .addr, .bank_open,
   .rd_issue, .wr_issue, .ap_pulse, .self_refresh, .dll_enable, .int_refresh);

/* File: tb/ddr2_command_bank_refresh_rules_test.sv */
`timescale 1ns/1ps
// Drives the core through the controller model and scores its results.
module ddr2_command_bank_refresh_rules_test;
   import dcb_pkg::*;
   localparam logic [3:0] C_ACT = 4'h3, C_RD = 4'h5, C_WR = 4'h4, C_PRE = 4'h2, C_REF = 4'h1;
   logic sys_clk = 1'b0, rst = 1'b1, cke = 1'b1, burst_eight = 1'b0;
   logic [2:0] add_lat = 3'h0, wr_recovery = 3'h2, issue_bank, ap_bank;
   wire logic cs_n, ras_n, cas_n, we_n;
   wire logic odt;
   wire logic [2:0] bank;
   wire logic [12:0] addr;
   logic [7:0] bank_open;
   logic [12:0] open_row [8];
   logic [12:0] a;
   logic rd_issue, wr_issue, ap_pulse, self_refresh, dll_enable, int_refresh;
   logic [9:0] issue_col;
   logic [15:0] refresh_count;
   logic [16:0] q [$];
   int seed = 32'h43b7d9fc;
   int num_errors = 0, checked = 0, nref = 0, self_refs = 0;
   // Clock at 40 MHz.
   always #12.5 sys_clk = ~sys_clk;
   dcb_ctrl_model ctrl (.sys_clk, .cs_n, .ras_n, .cas_n, .we_n, .bank, .addr, .odt);
   dcb_core #(.SREF_CYCLES(8)) dut (.sys_clk, .rst, .cs_n, .ras_n, .cas_n, .we_n, .cke, .bank,
      .addr, .add_lat, .burst_eight, .wr_recovery, .bank_open, .open_row, .rd_issue, .wr_issue,
      .issue_bank, .issue_col, .ap_pulse, .ap_bank, .self_refresh, .dll_enable, .int_refresh,
      .refresh_count);
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : check
   // Read or write; notes the internal issue and any auto-precharge it should cause.
   task automatic access(input logic [3:0] c, logic [2:0] b, logic ap, logic open, int gap);
      a = 13'($random(seed)) & 13'h1bff | {2'h0, ap, 10'h0};
      if (open) q.push_back({c == C_RD, c == C_WR, 2'h0, b, a[9:0]});
      if (open && ap) q.push_back({4'h2, b, 10'h0});
      ctrl.cmd(c, b, a, gap);
   endtask : access
   task automatic results();
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // Every result pulse outside self refresh is matched with the oldest note; internal refreshes in self refresh are only counted.
   always @(negedge sys_clk) begin
      if (int_refresh && self_refresh) self_refs++;
      else if (rd_issue || wr_issue || ap_pulse || int_refresh)
         check({rd_issue, wr_issue, ap_pulse, int_refresh, ap_pulse ? {ap_bank, 10'h0} :
            int_refresh ? 13'h0 : {issue_bank, issue_col}},
            q.size() > 0 ? q.pop_front() : 'x);
   end
   // Main sequence.
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      check({bank_open, dll_enable, self_refresh}, 10'h002);
      for (int b = 0; b < 8; b++) begin
         a = 13'($random(seed));
         ctrl.cmd(C_ACT, 3'(b), a, 2);
         check({bank_open[b], open_row[b]}, {1'b1, a});
      end
      for (int al = 0; al <= AL_MAX; al++) begin
         add_lat <= 3'(al);
         access(al[0] ? C_RD : C_WR, 3'(al), 1'b0, 1'b1, 8);
      end
      ctrl.cmd(C_PRE, 3'($random(seed)), 13'h0400, 3);
      check(bank_open, 8'h00);
      access(C_RD, 3'h4, 1'b0, 1'b0, 8);
      add_lat <= 3'h2;
      ctrl.cmd(C_ACT, 3'h2, 13'($random(seed)), 0);
      access(C_RD, 3'h2, 1'b1, 1'b1, 8);
      check(bank_open[2], 1'b0);
      add_lat <= 3'h0;
      ctrl.cmd(C_ACT, 3'h3, 13'($random(seed)), 0);
      access(C_RD, 3'h3, 1'b1, 1'b1, 8);
      check(bank_open[3], 1'b0);
      {add_lat, burst_eight, wr_recovery} <= 7'h1b;
      ctrl.cmd(C_ACT, 3'h5, 13'($random(seed)), 0);
      access(C_WR, 3'h5, 1'b1, 1'b1, 12);
      check(bank_open[5], 1'b0);
      ctrl.cmd(C_ACT, 3'h1, 13'h0, 8);
      q.push_back(17'h02000);
      nref++;
      ctrl.cmd(C_REF, 3'h0, 13'h0, 8);
      check(bank_open, 8'h00);
      cke <= 1'b0;
      // The core decodes a synchronised CKE, so it must be low two edges ahead.
      ctrl.nop(2);
      ctrl.cmd(C_REF, 3'h0, 13'h0, 2);
      check({self_refresh, dll_enable, odt}, 3'b100);
      ctrl.cmd(C_ACT, 3'h6, 13'h0, 30);
      check({bank_open, self_refs > 0}, 9'h001);
      cke <= 1'b1;
      ctrl.nop(8);
      check({self_refresh, dll_enable}, 2'b01);
      q.push_back(17'h02000);
      nref++;
      ctrl.cmd(C_REF, 3'h0, 13'h0, 8);
      check({refresh_count, 16'(q.size())}, {16'(nref + self_refs), 16'h0});
      results();
   end
   // Cuts a hung run short.
   initial begin
      #100000;
      num_errors++;
      results();
   end
endmodule : ddr2_command_bank_refresh_rules_test
